// >>> core/tbd_half.sv
/*
 one 32-bit counter half: loads, or steps up or down by one, flags wraps.
 assumes load has priority over step from the controller.
*/
`timescale 1ns/10ps
module tbd_half #(
   parameter bit DOWN = 1'b0,
   parameter logic [31:0] RST_VAL = 32'h0
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   tbd_cnt_if.cnt c
);
   import tbd_pkg::*;
   typedef struct packed {
      tbd_word_t val;
   } tbd_half_s;
   tbd_half_s st_ff;
   tbd_half_s nxt_st;
   always_comb begin
      nxt_st = st_ff;
      if (c.load) begin
         nxt_st.val = c.load_val;
      end else if (c.step) begin
         nxt_st.val = DOWN ? st_ff.val - 32'h1 : st_ff.val + 32'h1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_ff <= '{val: RST_VAL};
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign c.value = st_ff.val;
   assign c.wrap = c.step && (DOWN ? (st_ff.val == 32'h0) : (st_ff.val == 32'hFFFFFFFF));
endmodule

// >>> core/tbd_top.sv
/*
 tick counter (64-bit, two halves) and 32-bit countdown timer with own exception.
 assumes a core pipeline issuing one special register move per cycle and a tick enable
 pulse from the same clock domain.
*/
`timescale 1ns/10ps
`include "tbd_consts.svh"
module tbd_top (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic tick_en_i,
   input wire tbd_pkg::tbd_op_e op_i,
   input wire tbd_pkg::tbd_spr_t spr_i,
   input wire tbd_pkg::tbd_word_t wr_data_i,
   input wire logic supervisor_i,
   input wire logic cd_ack_i,
   output logic rd_valid_o,
   output tbd_pkg::tbd_word_t rd_data_o,
   output logic invalid_spr_o,
   output logic priv_fault_o,
   output logic cd_exc_o
);
   import tbd_pkg::*;

   // what one core access turns out to be, once number, op and privilege are weighed
   typedef enum logic [3:0] {
      TBD_ACC_IDLE,
      TBD_ACC_TICK_WR_LO,
      TBD_ACC_TICK_WR_HI,
      TBD_ACC_TICK_RD_LO,
      TBD_ACC_TICK_RD_HI,
      TBD_ACC_CD_WR,
      TBD_ACC_CD_RD,
      TBD_ACC_PRIV,
      TBD_ACC_INVALID
   } tbd_acc_e;
   typedef struct packed {
      logic tick_wr_lo;
      logic tick_wr_hi;
      logic tick_rd_lo;
      logic tick_rd_hi;
      logic cd;
      logic legacy;
   } tbd_hit_s;
   typedef struct packed {
      logic rd_valid;
      tbd_word_t rd_data;
      logic invalid;
      logic priv;
      logic exc;
   } tbd_top_s;

   tbd_top_s st_ff;
   tbd_top_s nxt_st;
   tbd_hit_s hit;
   tbd_acc_e acc;
   logic cd_fire;
   tbd_cnt_if lo_if();
   tbd_cnt_if hi_if();
   tbd_cnt_if cd_if();

   ////////////////////////////////////////////////////////////////////////////
   // counters
   tbd_half #(.DOWN(1'b0), .RST_VAL(32'(`TBD_TICK_RST))) u_lo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .c(lo_if.cnt)
   );
   tbd_half #(.DOWN(1'b0), .RST_VAL(32'(`TBD_TICK_RST >> 32))) u_hi (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .c(hi_if.cnt)
   );
   tbd_half #(.DOWN(1'b1), .RST_VAL(`TBD_CD_RST)) u_cd (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .c(cd_if.cnt)
   );

   // both counters advance on the one tick enable; the upper half rides the lower's carry
   assign lo_if.step = tick_en_i;
   assign hi_if.step = lo_if.wrap;
   assign cd_if.step = tick_en_i;
   assign lo_if.load = (acc == TBD_ACC_TICK_WR_LO);
   assign hi_if.load = (acc == TBD_ACC_TICK_WR_HI);
   assign cd_if.load = (acc == TBD_ACC_CD_WR);
   assign lo_if.load_val = wr_data_i;
   assign hi_if.load_val = wr_data_i;
   assign cd_if.load_val = wr_data_i;

   ////////////////////////////////////////////////////////////////////////////
   // register number decode
   always_comb begin
      hit = '0;
      unique case (spr_i)
         `TBD_SPR_TICK_LOWER_WR: begin
            hit.tick_wr_lo = 1'b1;
         end
         `TBD_SPR_TICK_UPPER_WR: begin
            hit.tick_wr_hi = 1'b1;
         end
         `TBD_SPR_TICK_LOWER_RD: begin
            hit.tick_rd_lo = 1'b1;
         end
         `TBD_SPR_TICK_UPPER_RD: begin
            hit.tick_rd_hi = 1'b1;
         end
         `TBD_SPR_COUNTDOWN: begin
            hit.cd = 1'b1;
         end
         `TBD_SPR_LEGACY_LOW, `TBD_SPR_LEGACY_HIGH: begin
            hit.legacy = 1'b1;
         end
         // unknown numbers match nothing
         default: begin
            hit = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // access classification
   always_comb begin
      acc = TBD_ACC_IDLE;
      unique case (op_i)
         TBD_OP_NONE: begin
            acc = TBD_ACC_IDLE;
         end
         TBD_OP_TICK_READ: begin
            if (hit.tick_rd_lo) begin
               acc = TBD_ACC_TICK_RD_LO;
            end else if (hit.tick_rd_hi) begin
               acc = TBD_ACC_TICK_RD_HI;
            end else begin
               acc = TBD_ACC_INVALID;
            end
         end
         TBD_OP_MOVE_TO: begin
            if (hit.cd) begin
               acc = supervisor_i ? TBD_ACC_CD_WR : TBD_ACC_PRIV;
            end else if (hit.legacy) begin
               acc = TBD_ACC_INVALID;
            end else if (hit.tick_wr_lo) begin
               acc = TBD_ACC_TICK_WR_LO;
            end else if (hit.tick_wr_hi) begin
               acc = TBD_ACC_TICK_WR_HI;
            end else begin
               acc = TBD_ACC_INVALID;
            end
         end
         TBD_OP_MOVE_FROM: begin
            if (hit.cd) begin
               acc = supervisor_i ? TBD_ACC_CD_RD : TBD_ACC_PRIV;
            end else if (hit.legacy) begin
               acc = TBD_ACC_INVALID;
            end else begin
               // tick numbers are not readable this way
               acc = TBD_ACC_INVALID;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // exception request
   // a countdown write in the wrap cycle replaces the value, so no step to all ones
   assign cd_fire = cd_if.wrap && !cd_if.load;

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rd_valid = 1'b0;
      nxt_st.invalid = 1'b0;
      nxt_st.priv = 1'b0;
      unique case (acc)
         TBD_ACC_TICK_RD_LO: begin
            nxt_st.rd_valid = 1'b1;
            nxt_st.rd_data = lo_if.value;
         end
         TBD_ACC_TICK_RD_HI: begin
            nxt_st.rd_valid = 1'b1;
            nxt_st.rd_data = hi_if.value;
         end
         TBD_ACC_CD_RD: begin
            nxt_st.rd_valid = 1'b1;
            nxt_st.rd_data = cd_if.value;
         end
         TBD_ACC_PRIV: begin
            nxt_st.priv = 1'b1;
         end
         TBD_ACC_INVALID: begin
            nxt_st.invalid = 1'b1;
         end
         // writes and idle cycles answer nothing
         TBD_ACC_IDLE, TBD_ACC_TICK_WR_LO, TBD_ACC_TICK_WR_HI, TBD_ACC_CD_WR: begin
            nxt_st.rd_valid = 1'b0;
         end
      endcase
      // a wrap in the ack cycle wins, so no request is lost
      if (cd_ack_i) begin
         nxt_st.exc = 1'b0;
      end
      if (cd_fire) begin
         nxt_st.exc = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_valid_o = st_ff.rd_valid;
   assign rd_data_o = st_ff.rd_data;
   assign invalid_spr_o = st_ff.invalid;
   assign priv_fault_o = st_ff.priv;
   assign cd_exc_o = st_ff.exc;
endmodule

// >>> dv/tbd_checker.sv
/* port assertions for tbd_top.
   assumes one clock and a sync high reset. */
`timescale 1ns/10ps
module tbd_checker (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic tick_en_i,
   input wire tbd_pkg::tbd_op_e op_i,
   input wire tbd_pkg::tbd_spr_t spr_i,
   input wire logic supervisor_i,
   input wire logic cd_ack_i,
   input wire logic rd_valid_o,
   input wire logic invalid_spr_o,
   input wire logic priv_fault_o,
   input wire logic cd_exc_o
);
   import tbd_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_tick_read: assert property (op_i == TBD_OP_TICK_READ && spr_i == 10'h10D |=> rd_valid_o)
      else $error("tick read unanswered");
   a_read_refused: assert property (op_i == TBD_OP_MOVE_FROM && spr_i == 10'h10C |=> invalid_spr_o)
      else $error("tick move read taken");
   a_legacy_bad: assert property (op_i inside {TBD_OP_MOVE_TO, TBD_OP_MOVE_FROM}
      && spr_i[9:1] == 9'h002 |=> invalid_spr_o && !rd_valid_o)
      else $error("legacy number taken");
   a_user_fault: assert property (op_i == TBD_OP_MOVE_FROM && spr_i == 10'h016
      && !supervisor_i |=> priv_fault_o && !rd_valid_o)
      else $error("user countdown read");
   a_idle_quiet: assert property (op_i == TBD_OP_NONE |=> !rd_valid_o && !invalid_spr_o)
      else $error("pulse without op");
   a_exc_hold: assert property (cd_exc_o && !cd_ack_i |=> cd_exc_o)
      else $error("exception dropped");
   a_exc_cause: assert property ($rose(cd_exc_o) |-> $past(tick_en_i))
      else $error("exception without tick");
   a_exc_clear: assert property ($fell(cd_exc_o) |-> $past(cd_ack_i))
      else $error("exception cleared unasked");
   c_exc: cover property ($rose(cd_exc_o));
   c_fault: cover property (priv_fault_o);
   c_wr_tick: cover property (tick_en_i && op_i == TBD_OP_MOVE_TO);
endmodule
bind tbd_top tbd_checker chk_i (.*);

// >>> dv/tbd_core.sv
/* core pipeline model: issues one register move a call.
   assumes calls begin on a falling edge. */
`timescale 1ns/10ps
module tbd_core (
   input wire logic ref_clk_i,
   output tbd_pkg::tbd_op_e op_o,
   output tbd_pkg::tbd_spr_t spr_o,
   output tbd_pkg::tbd_word_t data_o,
   output logic sup_o
);
   import tbd_pkg::*;
   initial begin
      op_o = TBD_OP_NONE;
      spr_o = 10'h000;
      data_o = 32'h0;
      sup_o = 1'h1;
   end
   task automatic issue(tbd_op_e o, tbd_spr_t s, tbd_word_t d, logic p);
      @(negedge ref_clk_i);
      op_o = o;
      spr_o = s;
      data_o = d;
      sup_o = p;
      @(negedge ref_clk_i);
      op_o = TBD_OP_NONE;
      data_o = ~d;
   endtask
endmodule

// >>> dv/testbench.sv
/* bench for tbd_top driven through the core model.
   assumes a 25 MHz clock and a sync high reset. */
`timescale 1ns/10ps
module testbench;
   import tbd_pkg::*;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, tick_en_i = 1'h0, cd_ack_i = 1'h0;
   logic supervisor_i, rd_valid_o, invalid_spr_o, priv_fault_o, cd_exc_o;
   tbd_op_e op_i;
   tbd_spr_t spr_i;
   tbd_word_t wr_data_i, rd_data_o;
   int fails = 0, compares = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   tbd_core core (.ref_clk_i, .op_o(op_i), .spr_o(spr_i), .data_o(wr_data_i),
      .sup_o(supervisor_i));
   tbd_top uut (.*);
   task automatic chk(logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic tick;
      @(negedge ref_clk_i) tick_en_i = 1'h1;
      @(negedge ref_clk_i) tick_en_i = 1'h0;
   endtask
   task automatic t_count;
      core.issue(TBD_OP_MOVE_TO, 10'h11C, 32'hFFFFFFFF, 1'h1);
      core.issue(TBD_OP_MOVE_TO, 10'h11D, 32'h5, 1'h1);
      tick;
      core.issue(TBD_OP_TICK_READ, 10'h10D, 32'h0, 1'h0);
      chk(rd_data_o, 32'h6);
      chk(rd_valid_o, 1'h1);
      core.issue(TBD_OP_MOVE_TO, 10'h11C, 32'hFFFFFFFF, 1'h1);
      fork
         tick;
         core.issue(TBD_OP_MOVE_TO, 10'h11C, 32'h10, 1'h1);
      join
      core.issue(TBD_OP_TICK_READ, 10'h10C, 32'h0, 1'h0);
      chk(rd_data_o, 32'h10);
      core.issue(TBD_OP_TICK_READ, 10'h10D, 32'h0, 1'h0);
      chk(rd_data_o, 32'h7);
      core.issue(TBD_OP_TICK_READ, 10'h016, 32'h0, 1'h0);
      chk(invalid_spr_o, 1'h1);
      core.issue(TBD_OP_MOVE_FROM, 10'h016, 32'h0, 1'h1);
      chk(rd_data_o, 32'hFFFFFFFD);
      core.issue(TBD_OP_MOVE_FROM, 10'h10C, 32'h0, 1'h1);
      chk(invalid_spr_o, 1'h1);
      for (int i = 0; i < 4; i++) begin
         core.issue(i[0] ? TBD_OP_MOVE_TO : TBD_OP_MOVE_FROM, {9'h002, i[1]}, 32'h0, 1'h1);
         chk(invalid_spr_o, 1'h1);
      end
   endtask
   task automatic t_exc;
      core.issue(TBD_OP_MOVE_TO, 10'h016, 32'h0, 1'h1);
      tick;
      chk(cd_exc_o, 1'h1);
      core.issue(TBD_OP_MOVE_FROM, 10'h016, 32'h0, 1'h0);
      chk(priv_fault_o, 1'h1);
      core.issue(TBD_OP_MOVE_TO, 10'h016, 32'h0, 1'h1);
      fork
         tick;
         begin
            @(negedge ref_clk_i) cd_ack_i = 1'h1;
            @(negedge ref_clk_i) cd_ack_i = 1'h0;
         end
      join
      chk(cd_exc_o, 1'h1);
      @(negedge ref_clk_i) cd_ack_i = 1'h1;
      @(negedge ref_clk_i) cd_ack_i = 1'h0;
      chk(cd_exc_o, 1'h0);
   endtask
   initial begin
      repeat (9) @(negedge ref_clk_i);
      rst_i = 1'h0;
      t_count;
      t_exc;
      give_verdict;
   end
   initial begin
      #20000;
      fails++;
      give_verdict;
   end
endmodule

// >>> include/tbd_cnt_if.sv
/*
 carrier between the top and the counter half module.
 assumes one clock domain.
*/
`timescale 1ns/10ps
interface tbd_cnt_if;
   import tbd_pkg::*;
   logic step;
   logic load;
   tbd_word_t load_val;
   tbd_word_t value;
   logic wrap;
   modport ctl (output step, output load, output load_val, input value, input wrap);
   modport cnt (input step, input load, input load_val, output value, output wrap);
endinterface

// >>> include/tbd_consts.svh
/*
 tick counter and countdown timer constants: register numbers, widths, reset values.
 assumes inclusion by bare name from package and modules.
*/
`ifndef TBD_CONSTS_SVH
`define TBD_CONSTS_SVH
`define TBD_SPR_W 10
`define TBD_SPR_TICK_LOWER_WR 10'h11C
`define TBD_SPR_TICK_UPPER_WR 10'h11D
`define TBD_SPR_TICK_LOWER_RD 10'h10C
`define TBD_SPR_TICK_UPPER_RD 10'h10D
`define TBD_SPR_COUNTDOWN 10'h016
`define TBD_SPR_LEGACY_LOW 10'h005
`define TBD_SPR_LEGACY_HIGH 10'h004
`define TBD_HALF_W 32
`define TBD_TICK_RST 64'h0
`define TBD_CD_RST 32'hFFFFFFFF
`endif

// >>> include/tbd_pkg.sv
/*
 types for the tick counter and countdown timer block.
 assumes tbd_consts.svh on the include path.
*/
`include "tbd_consts.svh"
package tbd_pkg;
   typedef logic [`TBD_SPR_W-1:0] tbd_spr_t;
   typedef logic [`TBD_HALF_W-1:0] tbd_word_t;
   typedef enum logic [1:0] {TBD_OP_NONE, TBD_OP_MOVE_TO, TBD_OP_MOVE_FROM, TBD_OP_TICK_READ}
      tbd_op_e;
endpackage
